// ---- core/rfic_consts.vh ----
// Purpose: constants of the reader frontend interrupt controller
// Assumes: 8-bit register port, all event sources on mclk
// Notes: every offset, field position and reset value lives here
//
// Operation
// - two flag registers, two enable registers
// - flag bit 7 selects set or clear
// - software writes raise or drop flags
// - each source masked by its enable bit
// - event sets status summary bit and pin
// - timer underflow sets its timer flag
// - data-to-end-of-frame sets transmit flag
// - end of received data sets receive flag
// - command returning to idle sets flag
// - one threshold value gives both levels
// - high status rising sets fifo high flag
// - low status rising sets fifo low flag
// - any receive error bit sets error
// - card detection sets card flag
// - start of frame sets its flag
// - global flag: any enabled source flagged
`ifndef RFIC_CONSTS_VH
`define RFIC_CONSTS_VH

// register port
`define RFIC_ADDR_W 4
`define RFIC_DATA_W 8
`define RFIC_ADDR_FLAGS0 4'h0
`define RFIC_ADDR_FLAGS1 4'h1
`define RFIC_ADDR_ENABLE0 4'h2
`define RFIC_ADDR_ENABLE1 4'h3
`define RFIC_ADDR_STATUS 4'h4
`define RFIC_ADDR_THRESH 4'h5
`define RFIC_ADDR_THRESH_EXT 4'h6

// flag register write selector
`define RFIC_SEL_BIT 7

// first_event_flags fields
`define RFIC_F0_TX_DONE 0
`define RFIC_F0_RX_DONE 1
`define RFIC_F0_CMD_IDLE 2
`define RFIC_F0_FIFO_HIGH 3
`define RFIC_F0_FIFO_LOW 4
`define RFIC_F0_RX_ERR 5
`define RFIC_F0_CARD 6

// second_event_flags fields
`define RFIC_F1_TIMER_LSB 0
`define RFIC_F1_TIMER_N 4
`define RFIC_F1_RX_SOF 5
`define RFIC_F1_GLOBAL 6

// enable register control bits
`define RFIC_EN0_PIN_INVERT 7
`define RFIC_EN1_PIN_ENABLE 7

// primary_status_register fields
`define RFIC_ST_IRQ 0
`define RFIC_ST_FIFO_HIGH 1
`define RFIC_ST_FIFO_LOW 2

// reset values
`define RFIC_RST_FLAGS 7'h00
`define RFIC_RST_ENABLE 8'h00
`define RFIC_RST_THRESH 8'h08
`define RFIC_RST_THRESH_EXT 1'b0

// fifo geometry and command code
`define RFIC_FIFO_DEPTH 512
`define RFIC_FIFO_CNT_W 10
`define RFIC_IDLE_CMD 4'h0
`define RFIC_CMD_W 4

`endif

// ---- core/rfic_rise_det.v ----
// Purpose: rising edge detector for a vector of same-clock levels
// Assumes: inputs already in the mclk domain
// Notes: history clears to zero, so a level high out of reset counts as an edge
module rfic_rise_det #(
  parameter W = 1
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // levels in, pulses out
  input wire [W-1:0] level,
  output wire [W-1:0] rise
);

  reg [W-1:0] prev_q;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_q <= {W{1'b0}};
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;

endmodule // rfic_rise_det

// ---- core/rfic_irq_ctrl.v ----
// Purpose: interrupt controller, flag and enable registers, request pin
// Assumes: every event source runs on mclk; single-cycle register strobes
// Notes: read data is registered and valid only in the cycle after the strobe
`include "rfic_consts.vh"

module rfic_irq_ctrl #(
  parameter FIFO_DEPTH = `RFIC_FIFO_DEPTH,
  parameter CNT_W = `RFIC_FIFO_CNT_W,
  parameter CMD_W = `RFIC_CMD_W
) (
  // clock and reset
  input wire mclk,
  input wire rst,

  // register port
  input wire [`RFIC_ADDR_W-1:0] reg_addr,
  input wire [`RFIC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [`RFIC_DATA_W-1:0] reg_rdata,

  // timer unit
  input wire [`RFIC_F1_TIMER_N-1:0] timer_underflow,

  // transmitter and receiver
  input wire tx_data_to_eof,
  input wire rx_data_end,
  input wire rx_sof_seen,
  input wire [7:0] rx_error_bits,

  // command register
  input wire [CMD_W-1:0] command_code,

  // fifo level monitor
  input wire [CNT_W-1:0] fifo_fill_count,

  // low-power card detection
  input wire card_detected,

  // threshold view for the fifo logic
  output wire [CNT_W-1:0] fifo_top_level,
  output wire fifo_high_status,
  output wire fifo_low_status,

  // interrupt request
  output wire irq_pin,
  output wire irq_summary
);

  localparam [CNT_W-1:0] DEPTH_C = FIFO_DEPTH[CNT_W-1:0];
  localparam [CMD_W-1:0] IDLE_C = `RFIC_IDLE_CMD;

  // register state
  reg [6:0] flags0_q;
  reg [6:0] flags0_d;
  reg [6:0] flags1_q;
  reg [6:0] flags1_d;
  reg [7:0] enable0_q;
  reg [7:0] enable1_q;
  reg [7:0] thresh_q;
  reg thresh_ext_q;
  reg [7:0] rdata_q;
  reg irq_q;
  reg [CMD_W-1:0] cmd_prev_q;

  // software strobes, decoded
  wire wr_flags0;
  wire wr_flags1;
  wire wr_enable0;
  wire wr_enable1;
  wire wr_thresh;
  wire wr_thresh_ext;
  wire sel_set;
  wire [6:0] sw_set;
  wire [6:0] sw_clr;

  // hardware events
  wire [6:0] hw_set0;
  wire [6:0] hw_set1;
  wire [1:0] fifo_rise;
  wire idle_event;
  wire err_event;

  // threshold arithmetic
  wire [CNT_W-1:0] level_ext;
  wire [CNT_W-1:0] top_level;
  wire [CNT_W-1:0] low_level;
  wire high_st;
  wire low_st;

  // summary
  wire [6:0] live0;
  wire [6:0] live1;
  wire any_enabled;
  wire pin_level;

  // address decode
  assign wr_flags0 = reg_wr && (reg_addr == `RFIC_ADDR_FLAGS0);
  assign wr_flags1 = reg_wr && (reg_addr == `RFIC_ADDR_FLAGS1);
  assign wr_enable0 = reg_wr && (reg_addr == `RFIC_ADDR_ENABLE0);
  assign wr_enable1 = reg_wr && (reg_addr == `RFIC_ADDR_ENABLE1);
  assign wr_thresh = reg_wr && (reg_addr == `RFIC_ADDR_THRESH);
  assign wr_thresh_ext = reg_wr && (reg_addr == `RFIC_ADDR_THRESH_EXT);

  // bit 7 picks the direction, bits 0 to 6 pick the flags
  assign sel_set = reg_wdata[`RFIC_SEL_BIT];
  assign sw_set = sel_set ? reg_wdata[6:0] : 7'h00;
  assign sw_clr = sel_set ? 7'h00 : reg_wdata[6:0];

  // fifo thresholds from one value plus extension
  assign level_ext = {{(CNT_W-9){1'b0}}, thresh_ext_q, thresh_q};
  assign top_level = DEPTH_C - level_ext;
  assign low_level = level_ext;
  assign high_st = (fifo_fill_count >= top_level);
  assign low_st = (fifo_fill_count <= low_level);
  assign fifo_top_level = top_level;
  assign fifo_high_status = high_st;
  assign fifo_low_status = low_st;

  // status edges: a level held high sets its flag once only
  rfic_rise_det #(
    .W(2)
  ) u_fifo_rise (
    .mclk(mclk),
    .rst(rst),
    .level({low_st, high_st}),
    .rise(fifo_rise)
  );

  // command finished: code moves from a running command to idle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_prev_q <= IDLE_C;
    end else begin
      cmd_prev_q <= command_code;
    end
  end

  assign idle_event = (cmd_prev_q != IDLE_C) && (command_code == IDLE_C);

  // error bits are a level: the flag is reasserted while any stays high,
  // so software must clear the error register before the flag will stay down
  assign err_event = |rx_error_bits;

  // hardware set vectors for the first flag register
  assign hw_set0[`RFIC_F0_TX_DONE] = tx_data_to_eof;
  assign hw_set0[`RFIC_F0_RX_DONE] = rx_data_end;
  assign hw_set0[`RFIC_F0_CMD_IDLE] = idle_event;
  assign hw_set0[`RFIC_F0_FIFO_HIGH] = fifo_rise[0];
  assign hw_set0[`RFIC_F0_FIFO_LOW] = fifo_rise[1];
  assign hw_set0[`RFIC_F0_RX_ERR] = err_event;
  assign hw_set0[`RFIC_F0_CARD] = card_detected;

  // hardware set vectors for the second flag register
  assign hw_set1[`RFIC_F1_TIMER_N-1:`RFIC_F1_TIMER_LSB] = timer_underflow;
  assign hw_set1[4] = 1'b0;
  assign hw_set1[`RFIC_F1_RX_SOF] = rx_sof_seen;
  assign hw_set1[`RFIC_F1_GLOBAL] = 1'b0;

  // masked view of the sources, global bit excluded from its own term
  assign live0 = flags0_q & enable0_q[6:0];
  assign live1 = flags1_q & enable1_q[6:0] & 7'h3f;
  assign any_enabled = (|live0) | (|live1);

  // first flag register: hardware set wins over a software clear
  always @* begin
    flags0_d = flags0_q;
    if (wr_flags0) begin
      flags0_d = (flags0_d | sw_set) & ~sw_clr;
    end
    flags0_d = flags0_d | hw_set0;
  end

  // second flag register: global bit tracks the enabled sources
  always @* begin
    flags1_d = flags1_q;
    if (wr_flags1) begin
      flags1_d = (flags1_d | sw_set) & ~sw_clr;
    end
    flags1_d = flags1_d | hw_set1;
    flags1_d[4] = 1'b0;
    flags1_d[`RFIC_F1_GLOBAL] = any_enabled;
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags0_q <= `RFIC_RST_FLAGS;
      flags1_q <= `RFIC_RST_FLAGS;
    end else begin
      flags0_q <= flags0_d;
      flags1_q <= flags1_d;
    end
  end

  // enable registers, plain read-write
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      enable0_q <= `RFIC_RST_ENABLE;
      enable1_q <= `RFIC_RST_ENABLE;
    end else begin
      if (wr_enable0) begin
        enable0_q <= reg_wdata;
      end
      if (wr_enable1) begin
        enable1_q <= reg_wdata;
      end
    end
  end

  // threshold value and its extension bit
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      thresh_q <= `RFIC_RST_THRESH;
      thresh_ext_q <= `RFIC_RST_THRESH_EXT;
    end else begin
      if (wr_thresh) begin
        thresh_q <= reg_wdata;
      end
      if (wr_thresh_ext) begin
        thresh_ext_q <= reg_wdata[0];
      end
    end
  end

  // request pin: lags the global flag by one cycle, held while it stays set;
  // the extra stage keeps the pin glitch free at the cost of a cycle
  assign pin_level = flags1_q[`RFIC_F1_GLOBAL] & enable1_q[`RFIC_EN1_PIN_ENABLE];

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pin_level ^ enable0_q[`RFIC_EN0_PIN_INVERT];
    end
  end

  assign irq_pin = irq_q;
  assign irq_summary = flags1_q[`RFIC_F1_GLOBAL];

  // read data, registered, zero for unmapped offsets and idle cycles
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RFIC_ADDR_FLAGS0: begin
          rdata_q <= {1'b0, flags0_q};
        end
        `RFIC_ADDR_FLAGS1: begin
          rdata_q <= {1'b0, flags1_q};
        end
        `RFIC_ADDR_ENABLE0: begin
          rdata_q <= enable0_q;
        end
        `RFIC_ADDR_ENABLE1: begin
          rdata_q <= enable1_q;
        end
        `RFIC_ADDR_STATUS: begin
          rdata_q <= {5'h00, low_st, high_st, flags1_q[`RFIC_F1_GLOBAL]};
        end
        `RFIC_ADDR_THRESH: begin
          rdata_q <= thresh_q;
        end
        `RFIC_ADDR_THRESH_EXT: begin
          rdata_q <= {7'h00, thresh_ext_q};
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // rfic_irq_ctrl

// ---- test/rfic_irq_monitor.sv ----
// Purpose: port checker for the interrupt controller
// Assumes: one clock, async high reset
// Notes: flags seen through reads, the global flag also at irq_summary
module rfic_irq_monitor (
  // clock and reset
  input wire mclk,
  input wire rst,
  // register port
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // source
  input wire tx_data_to_eof,
  // fifo and request
  input wire [9:0] fifo_fill_count,
  input wire [9:0] fifo_top_level,
  input wire fifo_high_status,
  input wire fifo_low_status,
  input wire irq_pin,
  input wire irq_summary
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd0 = reg_rd && reg_addr == 4'h0;
  a_sel_reads_zero: assert property (rd0 |=> !reg_rdata[7]) else $error("bit 7 read set");
  a_tx_flag_set: assert property (rd0 && $past(tx_data_to_eof) |=> reg_rdata[0]) else $error("tx flag");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data stuck");
  a_status_view: assert property (reg_rd && reg_addr == 4'h4 |=>
    reg_rdata[2:0] == {$past(fifo_low_status), $past(fifo_high_status), $past(irq_summary)})
    else $error("status view");
  a_high_level: assert property (fifo_high_status == (fifo_fill_count >= fifo_top_level))
    else $error("high");
  a_low_level: assert property (fifo_low_status == (fifo_fill_count <= 10'h200 - fifo_top_level))
    else $error("low");
  a_global_drop: assert property ($fell(irq_summary) |-> $past(reg_wr, 2)) else $error("global fell");
  // pin moves only after a config write or a change of the global flag; a flag
  // clear with invert on raises the pin three cycles after the write, not two
  a_pin_cause: assert property ($changed(irq_pin) && !$past(reg_wr, 2) |->
    $past(irq_summary) != $past(irq_summary, 2)) else $error("pin");
  cover property ($rose(irq_pin));
  cover property ($fell(irq_summary));
  cover property ($rose(fifo_high_status));
endmodule // rfic_irq_monitor

bind rfic_irq_ctrl rfic_irq_monitor mon (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data_to_eof(tx_data_to_eof), .fifo_fill_count(fifo_fill_count),
  .fifo_top_level(fifo_top_level), .fifo_high_status(fifo_high_status), .fifo_low_status(fifo_low_status),
  .irq_pin(irq_pin), .irq_summary(irq_summary));

// ---- test/rfic_src_model.sv ----
// Purpose: event sources beside the controller
// Assumes: one pulse per request
// Notes: command leaves idle for one cycle only
module rfic_src_model (
  // clock and reset
  input wire mclk,
  input wire rst,
  // request
  input wire go,
  input wire [3:0] sel,
  // sources
  output reg [3:0] tmr,
  output reg tx,
  output reg rxe,
  output reg sof,
  output reg [7:0] err,
  output reg [3:0] cmd,
  output reg card
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      {tmr, tx, rxe, sof, err, cmd, card} <= 20'h0_0000;
    end else begin
      tmr <= (go && sel < 4'h4) ? 4'h1 << sel : 4'h0;
      tx <= go && sel == 4'h4;
      rxe <= go && sel == 4'h5;
      cmd <= (go && sel == 4'h6) ? 4'h3 : 4'h0;
      err <= (go && sel == 4'h7) ? 8'h40 : 8'h00;
      card <= go && sel == 4'h8;
      sof <= go && sel == 4'h9;
    end
  end
endmodule // rfic_src_model

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the interrupt controller
// Assumes: 10 MHz mclk, source model makes events
// Notes: fifo count starts mid-range so level flags stay quiet until the level checks
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0;
  reg [3:0] reg_addr = 4'h0, sel = 4'h0;
  reg [7:0] reg_wdata = 8'h00, m, d;
  reg [9:0] fill = 10'h064;
  reg [15:0] e;
  wire [7:0] reg_rdata, err;
  wire [3:0] tmr, cmd;
  wire [9:0] top;
  wire tx, rxe, sof, card, hi, lo, irq_pin, irq_summary;
  integer miscompares = 0, comparisons = 0, seed = 64451, i;
  always #50 mclk = ~mclk;
  rfic_irq_ctrl uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_underflow(tmr), .tx_data_to_eof(tx), .rx_data_end(rxe),
    .rx_sof_seen(sof), .rx_error_bits(err), .command_code(cmd), .fifo_fill_count(fill), .card_detected(card),
    .fifo_top_level(top), .fifo_high_status(hi), .fifo_low_status(lo), .irq_pin(irq_pin),
    .irq_summary(irq_summary));
  rfic_src_model src (.mclk(mclk), .rst(rst), .go(go), .sel(sel), .tmr(tmr), .tx(tx), .rxe(rxe), .sof(sof),
    .err(err), .cmd(cmd), .card(card));
  task chk(input [9:0] got, input [9:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge mclk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] x);
    begin
      @(posedge mclk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'h0;
      @(negedge mclk);
      chk({2'h0, reg_rdata}, {2'h0, x});
    end
  endtask
  task fire(input [3:0] s);
    begin
      @(posedge mclk);
      go <= 1'h1;
      sel <= s;
      @(posedge mclk);
      go <= 1'h0;
    end
  endtask
  // flag expected per source: first register high byte
  function [15:0] expf(input [3:0] s);
    case (s)
      4'h4: expf = 16'h0100;
      4'h5: expf = 16'h0200;
      4'h6: expf = 16'h0400;
      4'h7: expf = 16'h2000;
      4'h8: expf = 16'h4000;
      4'h9: expf = 16'h0020;
      default: expf = 16'h0001 << s;
    endcase
  endfunction
  task pause;
    repeat (4) @(negedge mclk);
  endtask
  task results;
    begin
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    for (i = 0; i < 7; i = i + 1) rd(i[3:0], i == 5 ? 8'h08 : 8'h00);
    rd(4'hb, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h7f);
    wr(4'h0, 8'h05);
    rd(4'h0, 8'h7a);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h2f);
    m = 8'h7a;
    for (i = 0; i < 16; i = i + 1) begin
      d = $random(seed);
      wr(4'h0, d);
      m = d[7] ? m | {1'h0, d[6:0]} : m & ~{1'h0, d[6:0]};
      rd(4'h0, m);
    end
    for (i = 0; i < 10; i = i + 1) begin
      wr(4'h0, 8'h7f);
      wr(4'h1, 8'h7f);
      fire(i[3:0]);
      e = expf(i[3:0]);
      // idle flag lands one cycle after the code returns to idle
      if (i == 6) @(posedge mclk);
      rd(4'h0, e[15:8]);
      rd(4'h1, e[7:0]);
    end
    wr(4'h0, 8'h7f);
    wr(4'h1, 8'h7f);
    wr(4'h2, 8'h01);
    wr(4'h3, 8'h80);
    fire(4'h4);
    pause;
    chk({irq_pin, irq_summary}, 10'h003);
    rd(4'h4, 8'h01);
    wr(4'h2, 8'h00);
    pause;
    chk({irq_pin, irq_summary}, 10'h000);
    wr(4'h2, 8'h01);
    pause;
    chk({irq_pin, irq_summary}, 10'h003);
    wr(4'h0, 8'h01);
    pause;
    chk({irq_pin, irq_summary}, 10'h000);
    wr(4'h2, 8'h80);
    wr(4'h3, 8'h81);
    wr(4'h1, 8'h81);
    pause;
    chk({irq_pin, irq_summary}, 10'h001);
    wr(4'h1, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h10);
    pause;
    chk(top, 10'h1f0);
    @(posedge mclk) fill <= 10'h010;
    pause;
    rd(4'h0, 8'h10);
    rd(4'h4, 8'h04);
    chk({hi, lo}, 10'h001);
    @(posedge mclk) fill <= 10'h1f0;
    pause;
    rd(4'h0, 8'h18);
    chk({hi, lo}, 10'h002);
    wr(4'h6, 8'h01);
    pause;
    chk(top, 10'h0f0);
    results;
  end
endmodule // tb_top
